// [rtl/pwmu_pkg.sv]
`default_nettype none
package pwmu_pkg;
   // --------------------------------------------------------------
   // register offsets (byte addresses)
   // --------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_SRC     = 8'h04;
   localparam logic [7:0] OFS_PRESC   = 8'h08;
   localparam logic [7:0] OFS_COUNT   = 8'h0C;
   localparam logic [7:0] OFS_PCOUNT  = 8'h10;
   localparam logic [7:0] OFS_MCTL    = 8'h14;
   localparam logic [7:0] OFS_OUTCTL  = 8'h18;
   localparam logic [7:0] OFS_RELEASE = 8'h1C;
   localparam logic [7:0] OFS_STATUS  = 8'h20;
   localparam logic [7:0] OFS_MASK    = 8'h24;
   localparam logic [7:0] OFS_MATCH0  = 8'h40;
   localparam logic [7:0] OFS_MATCH6  = 8'h58;
   // --------------------------------------------------------------
   // field layout
   // --------------------------------------------------------------
   localparam int NMATCH      = 7;
   localparam int NOUT        = 6;
   localparam int SRC_MODE_LO = 0;
   localparam int SRC_SEL_LO  = 2;
   localparam int OUT_OE_LO   = 8;
   localparam int MCTL_W      = 3;
   // --------------------------------------------------------------
   // reset values
   // --------------------------------------------------------------
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [6:0]  RST_BITS = 7'h00;
   // --------------------------------------------------------------
   // count source modes
   // --------------------------------------------------------------
   localparam logic [1:0] SRC_TIMER = 2'h0;
   localparam logic [1:0] SRC_RISE  = 2'h1;
   localparam logic [1:0] SRC_FALL  = 2'h2;
   localparam logic [1:0] SRC_BOTH  = 2'h3;

   typedef struct packed {
      logic follow;
      logic pwm_on;
      logic clr;
      logic en;
   } pwmu_ctrl_t;

   typedef struct packed {
      logic stop;
      logic rst;
      logic int_en;
   } pwmu_mact_t;
endpackage : pwmu_pkg
`default_nettype wire

// [rtl/pwmu_count_src.sv]
`default_nettype none
module pwmu_count_src #(
   parameter int NCAP = 2,
   parameter int SELW = 1
) (
   input  wire logic            clk,
   input  wire logic            srst,
   input  wire logic            run,
   input  wire logic            clr,
   input  wire logic [1:0]      mode,
   input  wire logic [SELW-1:0] sel,
   input  wire logic [31:0]     presc,
   input  wire logic [NCAP-1:0] cap_in,
   output logic                 tick,
   output logic [31:0]          pc
);
   logic [NCAP-1:0] s1_reg, s2_reg, s3_reg;
   logic [31:0]     pc_reg, pc_next;
   logic            cur, prv, ev;

   // --------------------------------------------------------------
   // count event select
   // --------------------------------------------------------------
   always_comb begin
      cur = s2_reg[sel];
      prv = s3_reg[sel];
      // RL2 timer or counter
      case (mode)
         pwmu_pkg::SRC_TIMER: ev = 1'b1;
         pwmu_pkg::SRC_RISE:  ev = cur & ~prv;
         pwmu_pkg::SRC_FALL:  ev = ~cur & prv;
         default:             ev = cur ^ prv;
      endcase
      // RL1 prescale terminal
      tick    = run & ev & (pc_reg == presc);
      pc_next = pc_reg;
      if (clr) begin
         pc_next = pwmu_pkg::RST_WORD;
      end else if (tick) begin
         pc_next = pwmu_pkg::RST_WORD;
      end else if (run & ev) begin
         pc_next = pc_reg + 32'h0000_0001;
      end
   end

   // synchroniser free-runs through reset so no false edge follows it
   always_ff @(posedge clk) begin
      s1_reg <= cap_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (srst) begin
         pc_reg <= pwmu_pkg::RST_WORD;
      end else begin
         pc_reg <= pc_next;
      end
   end

   assign pc = pc_reg;

   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // RL2 no edge no count
   no_edge_tick_a: assert property ((mode != pwmu_pkg::SRC_TIMER && s2_reg[sel] == s3_reg[sel]) |-> !tick) // RL2
      else $error("count tick without capture edge");
   // RL1 prescale wrap
   presc_wrap_a: assert property (tick && !clr |=> pc_reg == 32'h0) // RL1
      else $error("prescale did not wrap at terminal");
endmodule : pwmu_count_src
`default_nettype wire

// [rtl/pwmu_edge_out.sv]
`default_nettype none
module pwmu_edge_out (
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic en,
   input  wire logic set,
   input  wire logic clr,
   output logic      out
);
   logic out_reg, out_next;

   always_comb begin
      out_next = out_reg;
      if (!en) begin
         out_next = 1'b0;
      // RL6 clear beats set
      end else if (clr) begin
         out_next = 1'b0;
      end else if (set) begin
         out_next = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         out_reg <= 1'b0;
      end else begin
         out_reg <= out_next;
      end
   end

   assign out = out_reg;

   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // RL5 edge placement
   out_rise_a: assert property (en && set && !clr |=> out) // RL5
      else $error("output not raised on set match");
   // RL6 constant low
   out_low_a: assert property ((!en || clr) |=> !out) // RL6
      else $error("output not low after clear match");
endmodule : pwmu_edge_out
`default_nettype wire

// [rtl/pwmu_top.sv]
// Behaviour
// RL1 - The 32-bit count advances once each time the 32-bit prescale counter reaches its terminal value.
// RL2 - The count source is either the clock (timer) or edges on a selected capture input (counter).
// RL3 - Seven match registers serve up to six single-edge or three double-edge outputs, or any mix.
// RL4 - Match 0 sets the cycle period by resetting the count, giving all outputs one rate.
// RL5 - A single-edge output rises at the period match and falls at its own match.
// RL6 - A single-edge output set to constant low does not rise at the cycle start.
// RL7 - A double-edge output takes its rise from the previous match and its fall from its own.
// RL8 - Rise before fall gives a positive pulse, fall before rise a negative one.
// RL9 - Period and width accept any count value.
// RL10 - New match values take effect only after software releases them, in step with the outputs.
// RL11 - Each match may continue, stop or reset the count, and may raise an interrupt.
// RL12 - With modulation off the unit is a plain timer with its matches still working.
// RL13 - Two units run in lock-step when set to one rate and enabled together, lead and follower.
// RL14 - Released values move into the active compares at the period reset.
`default_nettype none
module pwmu_top #(
   parameter int NCAP = 2,
   parameter int SELW = 1
) (
   input  wire logic            clk,
   input  wire logic            srst,
   input  wire logic [7:0]      addr,
   input  wire logic [31:0]     wdata,
   input  wire logic            wr,
   input  wire logic            rd,
   output logic [31:0]          rdata,
   input  wire logic [NCAP-1:0] cap_in,
   input  wire logic            sync_in,
   output logic                 sync_out,
   output logic [6:1]           pwm_out,
   output logic                 irq
);
   localparam int N = pwmu_pkg::NMATCH;

   pwmu_pkg::pwmu_ctrl_t          ctrl_reg, ctrl_next;
   pwmu_pkg::pwmu_mact_t [N-1:0]  mctl_reg, mctl_next;
   logic [SELW+1:0]               src_reg, src_next;
   logic [31:0]                   presc_reg, presc_next;
   logic [31:0]                   tc_reg, tc_next;
   logic [N-1:0][31:0]            sh_reg, sh_next;
   logic [N-1:0][31:0]            act_reg, act_next;
   logic [14:0]                   oc_reg, oc_next;
   logic [N-1:0]                  rel_reg, rel_next;
   logic [N-1:0]                  st_reg, st_next;
   logic [N-1:0]                  mask_reg, mask_next;
   logic [31:0]                   rdata_reg, rdata_next;
   logic                          irq_reg, sync_reg;
   logic                          run, tick, prst, any_rst, any_stop;
   logic [N-1:0]                  hit;
   logic [31:0]                   pc;
   logic [6:1]                    o_set, o_clr;
   logic                          w_ctrl, w_tc, w_rel, w_st;
   logic [N-1:0]                  w_m;

   // ------------------------------------------------------------------
   // count source and prescaler
   // ------------------------------------------------------------------
   // RL13 follower waits on lead
   assign run = ctrl_reg.en & ~ctrl_reg.clr & (~ctrl_reg.follow | sync_in);

   pwmu_count_src #(
      .NCAP (NCAP),
      .SELW (SELW)
   ) u_pwmu_count_src (
      .clk    (clk),
      .srst   (srst),
      .run    (run),
      .clr    (ctrl_reg.clr),
      .mode   (src_reg[1:0]),
      .sel    (src_reg[SELW+1:2]),
      .presc  (presc_reg),
      .cap_in (cap_in),
      .tick   (tick),
      .pc     (pc)
   );

   // ------------------------------------------------------------------
   // match compare
   // ------------------------------------------------------------------
   always_comb begin
      any_rst  = 1'b0;
      any_stop = 1'b0;
      for (int i = 0; i < N; i++) begin
         // RL9 any count value
         hit[i] = tick & (tc_reg == act_reg[i]);
         // RL11 match actions
         any_rst  = any_rst | (hit[i] & mctl_reg[i].rst);
         any_stop = any_stop | (hit[i] & mctl_reg[i].stop);
      end
      // RL4 period match resets count
      any_rst = any_rst | (hit[0] & ctrl_reg.pwm_on);
      prst    = hit[0] & ctrl_reg.pwm_on;
   end

   // ------------------------------------------------------------------
   // output edges
   // ------------------------------------------------------------------
   always_comb begin
      for (int n = 1; n <= pwmu_pkg::NOUT; n++) begin
         // RL5 single edge, RL7 double edge
         if (n >= 2 && oc_reg[n]) begin
            o_set[n] = hit[n-1];
         end else begin
            o_set[n] = hit[0];
         end
         o_clr[n] = hit[n];
      end
   end

   // RL3 six outputs from seven matches
   // RL8 pulse sense from match order
   for (genvar g = 1; g <= pwmu_pkg::NOUT; g++) begin : g_out
      pwmu_edge_out u_pwmu_edge_out (
         .clk  (clk),
         .srst (srst),
         .en   (ctrl_reg.pwm_on & oc_reg[pwmu_pkg::OUT_OE_LO+g-1]),
         .set  (o_set[g]),
         .clr  (o_clr[g]),
         .out  (pwm_out[g])
      );
   end

   // ------------------------------------------------------------------
   // register file and counter
   // ------------------------------------------------------------------
   always_comb begin
      w_ctrl = wr & (addr == pwmu_pkg::OFS_CTRL);
      w_tc   = wr & (addr == pwmu_pkg::OFS_COUNT);
      w_rel  = wr & (addr == pwmu_pkg::OFS_RELEASE);
      w_st   = wr & (addr == pwmu_pkg::OFS_STATUS);
      for (int i = 0; i < N; i++) begin
         w_m[i] = wr & (addr == 8'(pwmu_pkg::OFS_MATCH0 + 8'(4 * i)));
      end

      ctrl_next  = ctrl_reg;
      src_next   = src_reg;
      presc_next = presc_reg;
      mctl_next  = mctl_reg;
      oc_next    = oc_reg;
      mask_next  = mask_reg;
      if (w_ctrl) begin
         ctrl_next = wdata[3:0];
      end else if (wr && addr == pwmu_pkg::OFS_SRC) begin
         src_next = wdata[SELW+1:0];
      end else if (wr && addr == pwmu_pkg::OFS_PRESC) begin
         presc_next = wdata;
      end else if (wr && addr == pwmu_pkg::OFS_MCTL) begin
         mctl_next = wdata[N*pwmu_pkg::MCTL_W-1:0];
      end else if (wr && addr == pwmu_pkg::OFS_OUTCTL) begin
         oc_next = wdata[14:0];
      end else if (wr && addr == pwmu_pkg::OFS_MASK) begin
         mask_next = wdata[N-1:0];
      end
      // RL11 stop on match
      if (any_stop && !w_ctrl) begin
         ctrl_next.en = 1'b0;
      end

      // RL1 count advance
      tc_next = tc_reg;
      if (w_tc) begin
         tc_next = wdata;
      end else if (ctrl_reg.clr || (tick && any_rst)) begin
         tc_next = pwmu_pkg::RST_WORD;
      end else if (tick) begin
         tc_next = tc_reg + 32'h0000_0001;
      end

      sh_next  = sh_reg;
      act_next = act_reg;
      for (int i = 0; i < N; i++) begin
         if (w_m[i]) begin
            sh_next[i] = wdata;
         end
         // RL12 plain timer loads at once
         // RL14 load at period reset
         if (rel_reg[i] && (!ctrl_reg.pwm_on || prst)) begin
            act_next[i] = sh_reg[i];
         end
      end
      // RL10 release latch, set wins
      rel_next = rel_reg;
      if (ctrl_reg.pwm_on) begin
         rel_next = rel_reg & ~{N{prst}};
      end else begin
         rel_next = '0;
      end
      if (w_rel) begin
         rel_next = rel_next | wdata[N-1:0];
      end

      // RL11 match interrupt flags
      st_next = st_reg;
      if (w_st) begin
         st_next = st_reg & ~wdata[N-1:0];
      end
      for (int i = 0; i < N; i++) begin
         st_next[i] = st_next[i] | (hit[i] & mctl_reg[i].int_en);
      end

      rdata_next = 32'h0000_0000;
      if (!rd) begin
         rdata_next = 32'h0000_0000;
      end else if (addr == pwmu_pkg::OFS_CTRL) begin
         rdata_next[3:0] = ctrl_reg;
      end else if (addr == pwmu_pkg::OFS_SRC) begin
         rdata_next[SELW+1:0] = src_reg;
      end else if (addr == pwmu_pkg::OFS_PRESC) begin
         rdata_next = presc_reg;
      end else if (addr == pwmu_pkg::OFS_COUNT) begin
         rdata_next = tc_reg;
      end else if (addr == pwmu_pkg::OFS_PCOUNT) begin
         rdata_next = pc;
      end else if (addr == pwmu_pkg::OFS_MCTL) begin
         rdata_next[N*pwmu_pkg::MCTL_W-1:0] = mctl_reg;
      end else if (addr == pwmu_pkg::OFS_OUTCTL) begin
         rdata_next[14:0] = oc_reg;
      end else if (addr == pwmu_pkg::OFS_RELEASE) begin
         rdata_next[N-1:0] = rel_reg;
      end else if (addr == pwmu_pkg::OFS_STATUS) begin
         rdata_next[N-1:0] = st_reg;
      end else if (addr == pwmu_pkg::OFS_MASK) begin
         rdata_next[N-1:0] = mask_reg;
      end else if (addr >= pwmu_pkg::OFS_MATCH0 && addr <= pwmu_pkg::OFS_MATCH6 && addr[1:0] == 2'h0) begin
         rdata_next = sh_reg[3'(addr[4:2])];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl_reg  <= '0;
         src_reg   <= '0;
         presc_reg <= pwmu_pkg::RST_WORD;
         mctl_reg  <= '0;
         oc_reg    <= '0;
         tc_reg    <= pwmu_pkg::RST_WORD;
         sh_reg    <= '0;
         act_reg   <= '0;
         rel_reg   <= pwmu_pkg::RST_BITS;
         st_reg    <= pwmu_pkg::RST_BITS;
         mask_reg  <= pwmu_pkg::RST_BITS;
         rdata_reg <= pwmu_pkg::RST_WORD;
         irq_reg   <= 1'b0;
         sync_reg  <= 1'b0;
      end else begin
         ctrl_reg  <= ctrl_next;
         src_reg   <= src_next;
         presc_reg <= presc_next;
         mctl_reg  <= mctl_next;
         oc_reg    <= oc_next;
         tc_reg    <= tc_next;
         sh_reg    <= sh_next;
         act_reg   <= act_next;
         rel_reg   <= rel_next;
         st_reg    <= st_next;
         mask_reg  <= mask_next;
         rdata_reg <= rdata_next;
         irq_reg   <= |(st_next & mask_next);
         // RL13 lead start marker
         sync_reg  <= ctrl_next.en & ~ctrl_next.clr;
      end
   end

   assign rdata    = rdata_reg;
   assign irq      = irq_reg;
   assign sync_out = sync_reg;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (srst);

   // RL4 period count reset
   period_reset_a: assert property (prst && !w_tc |=> tc_reg == 32'h0) // RL4
      else $error("period match did not reset count");
   // RL1 count step
   count_step_a: assert property (tick && !any_rst && !w_tc && !ctrl_reg.clr |=> tc_reg == $past(tc_reg) + 32'h1) // RL1
      else $error("count did not advance by one");
   // RL11 stop holds count
   match_stop_a: assert property (any_stop && !w_ctrl |=> !ctrl_reg.en ##1 // RL11
      ($stable(tc_reg) || $past(w_tc) || $past(ctrl_reg.clr)))
      else $error("stop match left counter running");
   // RL14 load at reset
   release_load_a: assert property (prst && rel_reg[1] |=> act_reg[1] == $past(sh_reg[1])) // RL14
      else $error("released value not loaded at period reset");
   // RL10 compare held mid cycle
   active_hold_a: assert property (ctrl_reg.pwm_on && !prst |=> act_reg == $past(act_reg)) // RL10
      else $error("active compare changed mid cycle");
   // RL12 timer immediate load
   timer_load_a: assert property (!ctrl_reg.pwm_on && rel_reg[2] |=> act_reg[2] == $past(sh_reg[2])) // RL12
      else $error("plain timer did not take released value");
   // RL11 interrupt level
   irq_level_a: assert property (|(st_reg & mask_reg) |-> irq) // RL11
      else $error("interrupt low with unmasked flag set");
   // RL13 follower waits
   follow_wait_a: assert property (ctrl_reg.follow && !sync_in && !w_tc && !ctrl_reg.clr |=> $stable(tc_reg)) // RL13
      else $error("follower counted without lead");
   // RL7 double edge rise
   dbl_rise_a: assert property (ctrl_reg.pwm_on && oc_reg[3] && oc_reg[10] && hit[2] && !hit[3] // RL7
      |=> pwm_out[3])
      else $error("double edge output missed rising match");
endmodule : pwmu_top
`default_nettype wire

// [bench/pwmu_load.sv]
`default_nettype none
module pwmu_load (
   input  wire logic       clk,
   input  wire logic       gen,
   input  wire logic       meas,
   input  wire logic [6:1] pwm_out,
   output logic [1:0]      cap_in,
   output logic [6:1][7:0] hi_cnt
);
   timeunit 1ns;
   timeprecision 1ps;

   logic       meas_q = 1'b0;
   logic [1:0] ph     = 2'h0;
   logic [1:0] cap_q  = 2'h0;

   assign cap_in = cap_q;

   // ---------------------------------------------------------------
   // edge source: a rising edge on each line every 6 cycles
   // ---------------------------------------------------------------
   always @(posedge clk) begin
      if (gen) begin
         ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
         if (ph == 2'h2) begin
            cap_q <= {cap_q[0], ~cap_q[0]};
         end
      end
   end

   // ---------------------------------------------------------------
   // load side: high cycles of each output over a window
   // ---------------------------------------------------------------
   always @(posedge clk) begin
      meas_q <= meas;
      for (int i = 1; i <= 6; i++) begin
         if (meas && !meas_q) begin
            hi_cnt[i] <= 8'(pwm_out[i]);
         end else if (meas) begin
            hi_cnt[i] <= hi_cnt[i] + 8'(pwm_out[i]);
         end
      end
   end
endmodule : pwmu_load
`default_nettype wire

// [bench/tb_pwmu_top.sv]
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin error_cnt++; \
   $display("Error at %0t: got %h exp %h", $time, (got), (exp)); end end
module tb_pwmu_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic             clk = 1'b0;
   logic             srst = 1'b1;
   logic [7:0]       addr = 8'h00;
   logic [31:0]      wdata = 32'h0;
   logic             wr_a = 1'b0;
   logic             wr_b = 1'b0;
   logic             rd = 1'b0;
   logic             gen = 1'b0;
   logic             meas = 1'b0;
   logic [31:0]      rdata_a, rdata_b, qa, qb, d;
   logic [1:0]       cap_a;
   logic             sync_a, sync_b, irq_a, irq_b;
   logic [6:1]       pwm_a;
   logic [6:1][7:0]  hi_cnt;
   int               error_cnt = 0;
   int               num_checks = 0;
   int               cyc = 0;

   always #20 clk = ~clk;

   pwmu_top u_pwmu_top (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr_a), .rd(rd),
      .rdata(rdata_a), .cap_in(cap_a), .sync_in(1'b0), .sync_out(sync_a), .pwm_out(pwm_a), .irq(irq_a));
   pwmu_top u_pwmu_top_flw (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr_b), .rd(rd),
      .rdata(rdata_b), .cap_in(2'h0), .sync_in(sync_a), .sync_out(sync_b), .pwm_out(), .irq(irq_b));
   pwmu_load u_pwmu_load (.clk(clk), .gen(gen), .meas(meas), .pwm_out(pwm_a), .cap_in(cap_a),
      .hi_cnt(hi_cnt));

   // ---------------------------------------------------------------
   // bus and helper tasks
   // ---------------------------------------------------------------
   task automatic wr_reg(input bit sel, input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr  <= a;
      wdata <= v;
      wr_a  <= !sel;
      wr_b  <= sel;
      @(posedge clk);
      wr_a  <= 1'b0;
      wr_b  <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      qa = rdata_a;
      qb = rdata_b;
   endtask : rd_reg

   task automatic do_reset();
      @(posedge clk);
      srst <= 1'b1;
      repeat (6) @(posedge clk);
      srst <= 1'b0;
   endtask : do_reset

   task automatic measure(input int n);
      @(posedge clk);
      meas <= 1'b1;
      repeat (n) @(posedge clk);
      meas <= 1'b0;
      #1;
   endtask : measure

   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : stop_test

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   // prescaled count rate
   task automatic t_prescale();
      do_reset();
      rd_reg(pwmu_pkg::OFS_COUNT);
      `CHK(qa, pwmu_pkg::RST_WORD)
      wr_reg(0, 8'h30, 32'hFFFF_FFFF);
      rd_reg(8'h30);
      `CHK(qa, 32'h0)
      wr_reg(0, pwmu_pkg::OFS_PRESC, 32'h3);
      wr_reg(0, pwmu_pkg::OFS_CTRL, 32'h1);
      repeat (10) @(posedge clk);
      rd_reg(pwmu_pkg::OFS_COUNT);
      d = qa;
      repeat (6) @(posedge clk);
      rd_reg(pwmu_pkg::OFS_COUNT);
      `CHK(qa - d, 32'h2)
      rd_reg(pwmu_pkg::OFS_PCOUNT);
      `CHK(qa <= 32'h3, 1'b1)
      $display("test prescale done");
   endtask : t_prescale

   // count over a 60 cycle window in one source mode
   task automatic src_win(input logic [31:0] s, input logic [31:0] n);
      wr_reg(0, pwmu_pkg::OFS_SRC, s);
      rd_reg(pwmu_pkg::OFS_COUNT);
      d = qa;
      repeat (58) @(posedge clk);
      rd_reg(pwmu_pkg::OFS_COUNT);
      `CHK(qa - d, n)
   endtask : src_win

   task automatic t_counter();
      do_reset();
      gen <= 1'b1;
      wr_reg(0, pwmu_pkg::OFS_CTRL, 32'h1);
      src_win(32'(pwmu_pkg::SRC_RISE), 32'hA);
      src_win(32'(pwmu_pkg::SRC_FALL), 32'hA);
      src_win((32'h1 << pwmu_pkg::SRC_SEL_LO) | 32'(pwmu_pkg::SRC_BOTH), 32'h14);
      gen <= 1'b0;
      $display("test counter done");
   endtask : t_counter

   task automatic t_single();
      do_reset();
      wr_reg(0, pwmu_pkg::OFS_MATCH0, 32'h9);
      wr_reg(0, 8'h44, 32'h3);
      wr_reg(0, 8'h48, 32'h9);
      wr_reg(0, pwmu_pkg::OFS_OUTCTL, 32'h300);
      wr_reg(0, pwmu_pkg::OFS_RELEASE, 32'h7);
      wr_reg(0, pwmu_pkg::OFS_CTRL, 32'h5);
      repeat (40) @(posedge clk);
      measure(20);
      `CHK(hi_cnt[1], 8'h08)
      `CHK(hi_cnt[2], 8'h00)
      `CHK(hi_cnt[4], 8'h00)
      wr_reg(0, 8'h44, 32'h6);
      repeat (30) @(posedge clk);
      measure(20);
      `CHK(hi_cnt[1], 8'h08)
      wr_reg(0, pwmu_pkg::OFS_RELEASE, 32'h2);
      repeat (30) @(posedge clk);
      rd_reg(pwmu_pkg::OFS_RELEASE);
      `CHK(qa, 32'h0)
      measure(20);
      `CHK(hi_cnt[1], 8'h0E)
      wr_reg(0, 8'h44, 32'h0);
      wr_reg(0, pwmu_pkg::OFS_RELEASE, 32'h2);
      repeat (30) @(posedge clk);
      measure(20);
      `CHK(hi_cnt[1], 8'h02)
      $display("test single done");
   endtask : t_single

   // double edge pulses of both polarities
   task automatic t_double();
      do_reset();
      wr_reg(0, pwmu_pkg::OFS_MATCH0, 32'h9);
      wr_reg(0, 8'h44, 32'h4);
      wr_reg(0, 8'h48, 32'h2);
      wr_reg(0, 8'h4C, 32'h6);
      wr_reg(0, pwmu_pkg::OFS_OUTCTL, 32'h508);
      wr_reg(0, pwmu_pkg::OFS_RELEASE, 32'hF);
      wr_reg(0, pwmu_pkg::OFS_CTRL, 32'h5);
      repeat (40) @(posedge clk);
      measure(20);
      `CHK(hi_cnt[3], 8'h08)
      `CHK(hi_cnt[1], 8'h0A)
      wr_reg(0, 8'h48, 32'h7);
      wr_reg(0, 8'h4C, 32'h3);
      wr_reg(0, pwmu_pkg::OFS_RELEASE, 32'hC);
      repeat (30) @(posedge clk);
      measure(20);
      `CHK(hi_cnt[3], 8'h0C)
      `CHK(hi_cnt[1], 8'h0A)
      $display("test double done");
   endtask : t_double

   task automatic t_match_act();
      do_reset();
      wr_reg(0, 8'h44, 32'h5);
      wr_reg(0, pwmu_pkg::OFS_RELEASE, 32'h2);
      wr_reg(0, pwmu_pkg::OFS_MCTL, 32'h28);
      wr_reg(0, pwmu_pkg::OFS_MASK, 32'h2);
      #1;
      `CHK(irq_a, 1'b0)
      wr_reg(0, pwmu_pkg::OFS_CTRL, 32'h1);
      repeat (30) @(posedge clk);
      rd_reg(pwmu_pkg::OFS_CTRL);
      `CHK(qa, 32'h0)
      rd_reg(pwmu_pkg::OFS_STATUS);
      `CHK(qa, 32'h2)
      `CHK(irq_a, 1'b1)
      rd_reg(pwmu_pkg::OFS_COUNT);
      d = qa;
      repeat (5) @(posedge clk);
      rd_reg(pwmu_pkg::OFS_COUNT);
      `CHK(qa, d)
      wr_reg(0, pwmu_pkg::OFS_MASK, 32'h0);
      repeat (2) @(posedge clk);
      #1;
      `CHK(irq_a, 1'b0)
      wr_reg(0, pwmu_pkg::OFS_MASK, 32'h2);
      repeat (2) @(posedge clk);
      #1;
      `CHK(irq_a, 1'b1)
      wr_reg(0, pwmu_pkg::OFS_STATUS, 32'h2);
      repeat (2) @(posedge clk);
      #1;
      `CHK(irq_a, 1'b0)
      wr_reg(0, pwmu_pkg::OFS_MCTL, 32'h10);
      wr_reg(0, pwmu_pkg::OFS_COUNT, 32'h0);
      wr_reg(0, pwmu_pkg::OFS_CTRL, 32'h1);
      for (int i = 0; i < 6; i++) begin
         repeat (7) @(posedge clk);
         rd_reg(pwmu_pkg::OFS_COUNT);
         `CHK(qa <= 32'h5, 1'b1)
      end
      $display("test match actions done");
   endtask : t_match_act

   task automatic t_lockstep();
      do_reset();
      wr_reg(1, pwmu_pkg::OFS_CTRL, 32'h9);
      repeat (10) @(posedge clk);
      rd_reg(pwmu_pkg::OFS_COUNT);
      `CHK(qb, 32'h0)
      `CHK(sync_b, 1'b1)
      wr_reg(0, pwmu_pkg::OFS_CTRL, 32'h1);
      repeat (20) @(posedge clk);
      #1;
      `CHK(sync_a, 1'b1)
      rd_reg(pwmu_pkg::OFS_COUNT);
      `CHK(qb != 32'h0, 1'b1)
      `CHK(qa - qb, 32'h0)
      repeat (10) @(posedge clk);
      rd_reg(pwmu_pkg::OFS_COUNT);
      `CHK(qa - qb, 32'h0)
      `CHK(irq_b, 1'b0)
      $display("test lockstep done");
   endtask : t_lockstep

   // ---------------------------------------------------------------
   // main sequence and watchdog
   // ---------------------------------------------------------------
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         $display("Error at %0t: got %h exp %h", $time, cyc, 0);
         stop_test();
      end
   end

   initial begin
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      t_prescale();
      t_counter();
      t_single();
      t_double();
      t_match_act();
      t_lockstep();
      stop_test();
   end
endmodule : tb_pwmu_top
`default_nettype wire
